// *** include/pwbp_pkg.sv ***
// Shared constants and types of the word/byte pack-unpack data path.
package pwbp_pkg;

	// --------------------------------------------------------------
	// Data path sizes
	// --------------------------------------------------------------
	localparam int DATA_W = 16;
	localparam int REG_ADDR_W = 2;

	// --------------------------------------------------------------
	// Register offsets on the plain register port
	// --------------------------------------------------------------
	localparam logic [REG_ADDR_W-1:0] CTRL_OFS = 2'h0;
	localparam logic [REG_ADDR_W-1:0] STAT_OFS = 2'h1;

	// --------------------------------------------------------------
	// Control word fields
	// --------------------------------------------------------------
	localparam int CTRL_START_READ_BIT = 0;
	localparam int CTRL_PERM_ENABLE_BIT = 5;
	localparam int CTRL_TEST_WRITE_BIT = 7;
	localparam int CTRL_BYTE_XFER_BIT = 13;
	localparam logic [DATA_W-1:0] CTRL_RESET = 16'h0000;

	// --------------------------------------------------------------
	// Status word fields
	// --------------------------------------------------------------
	localparam int STAT_WIP_BIT = 1;
	localparam int STAT_SEQ_LSB = 3;
	localparam int STAT_FLAG_BIT = 5;
	localparam int STAT_BYTE_BIT = 6;

	// --------------------------------------------------------------
	// Sequence counter states
	// --------------------------------------------------------------
	typedef enum logic [1:0] {
		PWBP_SEQ_IDLE,
		PWBP_SEQ_REQ,
		PWBP_SEQ_RESP,
		PWBP_SEQ_SECOND
	} pwbp_seq_t;

endpackage

// *** design/pwbp_seq_counter.sv ***
// Two-bit transfer sequence counter stepped by the device flag handshake.
`timescale 1ns/1ns
module pwbp_seq_counter (
	// Clock and reset
	input  wire logic              sys_clk,
	input  wire logic              rst,
	// Control
	input  wire logic              start,
	input  wire logic              byte_mode,
	input  wire logic              device_flag,
	// Sequence state
	output pwbp_pkg::pwbp_seq_t    count,
	output pwbp_pkg::pwbp_seq_t    next_count,
	output logic                   op_done,
	output logic                   device_command
);
	import pwbp_pkg::*;

	typedef struct packed {
		pwbp_seq_t seq;
		logic      flag_d;
	} pwbp_seq_st_t;

	pwbp_seq_st_t q;
	pwbp_seq_st_t next_q;
	logic         flag_rise;
	logic         flag_fall;

	// --------------------------------------------------------------
	// Next state
	// --------------------------------------------------------------
	// Idle leaves only on start; a start seen mid-sequence is dropped
	// because the qualifier is armed only from idle.
	always_comb begin
		next_q = q;
		flag_rise = device_flag & ~q.flag_d;
		flag_fall = ~device_flag & q.flag_d;
		next_q.flag_d = device_flag;
		case (q.seq)
			PWBP_SEQ_IDLE: begin
				if (start) begin
					next_q.seq = PWBP_SEQ_REQ;
				end
			end
			PWBP_SEQ_REQ: begin
				if (flag_rise) begin
					next_q.seq = PWBP_SEQ_RESP;
				end
			end
			PWBP_SEQ_RESP: begin
				if (flag_fall) begin
					next_q.seq = byte_mode ? PWBP_SEQ_SECOND : PWBP_SEQ_IDLE;
				end
			end
			PWBP_SEQ_SECOND: begin
				if (flag_rise) begin
					next_q.seq = PWBP_SEQ_IDLE;
				end
			end
			default: begin
				next_q.seq = PWBP_SEQ_IDLE;
			end
		endcase
	end

	// --------------------------------------------------------------
	// State register
	// --------------------------------------------------------------
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			q <= '0;
		end else begin
			q <= next_q;
		end
	end

	// Outputs for the data path and the device request line.
	assign count = q.seq;
	assign next_count = next_q.seq;
	assign op_done = (q.seq != PWBP_SEQ_IDLE) &&
		(next_q.seq == PWBP_SEQ_IDLE);
	assign device_command = (q.seq == PWBP_SEQ_REQ) ||
		(q.seq == PWBP_SEQ_SECOND);
endmodule

// *** design/pwbp_regs.sv ***
// Control and status registers on the plain register port.
`timescale 1ns/1ns
module pwbp_regs (
	// Clock and reset
	input  wire logic                               sys_clk,
	input  wire logic                               rst,
	// Register port
	input  wire logic [pwbp_pkg::REG_ADDR_W-1:0]    reg_addr,
	input  wire logic [pwbp_pkg::DATA_W-1:0]        reg_wdata,
	input  wire logic                               reg_wr,
	input  wire logic                               reg_rd,
	output logic      [pwbp_pkg::DATA_W-1:0]        reg_rdata,
	// Block state in
	input  wire logic                               wip,
	input  pwbp_pkg::pwbp_seq_t                     count,
	input  wire logic                               device_flag,
	// Control out
	output logic                                    byte_mode,
	output logic                                    perm_enable,
	output logic                                    test_write,
	output logic                                    start_read
);
	import pwbp_pkg::*;

	typedef struct packed {
		logic [DATA_W-1:0] ctrl;
		logic [DATA_W-1:0] rdata;
	} pwbp_regs_st_t;

	pwbp_regs_st_t     q;
	pwbp_regs_st_t     next_q;
	logic [DATA_W-1:0] status;

	// --------------------------------------------------------------
	// Register update and read mux
	// --------------------------------------------------------------
	// The control word is held until software loads a new one, so the
	// byte mode stays steady across whole sequences.
	always_comb begin
		next_q = q;
		status = '0;
		status[STAT_WIP_BIT] = wip;
		status[STAT_SEQ_LSB +: 2] = count;
		status[STAT_FLAG_BIT] = device_flag;
		status[STAT_BYTE_BIT] = q.ctrl[CTRL_BYTE_XFER_BIT];
		if (reg_wr && reg_addr == CTRL_OFS) begin
			next_q.ctrl = reg_wdata;
			next_q.ctrl[CTRL_START_READ_BIT] = 1'b0;
		end
		next_q.rdata = '0;
		if (reg_rd) begin
			case (reg_addr)
				CTRL_OFS: next_q.rdata = q.ctrl;
				STAT_OFS: next_q.rdata = status;
				default:  next_q.rdata = '0;
			endcase
		end
	end

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			q <= '{ctrl: CTRL_RESET, rdata: '0};
		end else begin
			q <= next_q;
		end
	end

	assign reg_rdata = q.rdata;
	assign byte_mode = q.ctrl[CTRL_BYTE_XFER_BIT];
	assign perm_enable = q.ctrl[CTRL_PERM_ENABLE_BIT];
	assign test_write = q.ctrl[CTRL_TEST_WRITE_BIT];
	assign start_read = reg_wr && reg_addr == CTRL_OFS &&
		reg_wdata[CTRL_START_READ_BIT];
endmodule

// *** design/pwbp_core.sv ***
// Word/byte pack-unpack data path between host strobes and device lines.
// ----------------------------------------------------------------------
// How it works
// - Input takes whole words or two packed bytes.
// - Input held, shown to host on read strobe.
// - Word mode routes upper byte lines straight through.
// - Word load continuous or count 1, frozen after.
// - Byte mode first byte fills both halves.
// - Second byte loads upper half at count 3.
// - Read strobe then presents full packed word.
// - Write strobe latches host word into output.
// - Low bits driven direct; select low sends word.
// - Byte writes send low half first, then high.
// - Write flag set by strobe, cleared when done.
// - Write strobe starts counter from idle.
// - Byte mode follows control bit until reloaded.
// - Normal select needs write flag and byte mode.
// - Test write selects by byte mode alone.
// - Counter: idle, request, response, second byte.
// ----------------------------------------------------------------------
`timescale 1ns/1ns
module pwbp_core #(
	parameter int DATA_W = pwbp_pkg::DATA_W
) (
	// Clock and reset
	input  wire logic                            sys_clk,
	input  wire logic                            rst,
	// Host data strobes
	input  wire logic                            direct_read_strobe,
	input  wire logic                            program_read_strobe,
	input  wire logic                            direct_write_strobe,
	input  wire logic                            program_write_strobe,
	input  wire logic [DATA_W-1:0]               host_wdata,
	output logic      [DATA_W-1:0]               host_rdata,
	// Register port
	input  wire logic [pwbp_pkg::REG_ADDR_W-1:0] reg_addr,
	input  wire logic [pwbp_pkg::DATA_W-1:0]     reg_wdata,
	input  wire logic                            reg_wr,
	input  wire logic                            reg_rd,
	output logic      [pwbp_pkg::DATA_W-1:0]     reg_rdata,
	// Device lines
	input  wire logic [DATA_W-1:0]               dev_rx,
	input  wire logic                            device_flag,
	output logic      [DATA_W-1:0]               dev_tx,
	output logic                                 device_command
);
	import pwbp_pkg::*;

	localparam int HALF = DATA_W / 2;

	// --------------------------------------------------------------
	// Elaboration check
	// --------------------------------------------------------------
	// The register port carries the full word, so the width must match.
	if (DATA_W != pwbp_pkg::DATA_W || DATA_W % 2 != 0) begin : g_bad_w
		$error("pwbp_core: DATA_W must equal the package word width");
	end

	typedef struct packed {
		logic [DATA_W-1:0] hold;
		logic [DATA_W-1:0] out_word;
		logic [DATA_W-1:0] rd_data;
		logic [DATA_W-1:0] tx;
		logic              wip;
		logic              half_sel;
	} pwbp_core_st_t;

	pwbp_core_st_t q;
	pwbp_core_st_t next_q;
	pwbp_seq_t     count;
	pwbp_seq_t     next_count;
	logic          op_done;
	logic          byte_mode;
	logic          perm_enable;
	logic          test_write;
	logic          start_read;
	logic          rd_stb;
	logic          wr_stb;
	logic          load_upper;
	logic          load_lower;
	logic          sel_enable;

	assign rd_stb = direct_read_strobe | program_read_strobe;
	assign wr_stb = direct_write_strobe | program_write_strobe;

	// --------------------------------------------------------------
	// Sequence counter and registers
	// --------------------------------------------------------------
	pwbp_seq_counter u_seq (
		.sys_clk        (sys_clk),
		.rst            (rst),
		.start          (wr_stb | start_read),
		.byte_mode      (byte_mode),
		.device_flag    (device_flag),
		.count          (count),
		.next_count     (next_count),
		.op_done        (op_done),
		.device_command (device_command)
	);

	pwbp_regs u_regs (
		.sys_clk     (sys_clk),
		.rst         (rst),
		.reg_addr    (reg_addr),
		.reg_wdata   (reg_wdata),
		.reg_wr      (reg_wr),
		.reg_rd      (reg_rd),
		.reg_rdata   (reg_rdata),
		.wip         (q.wip),
		.count       (count),
		.device_flag (device_flag),
		.byte_mode   (byte_mode),
		.perm_enable (perm_enable),
		.test_write  (test_write),
		.start_read  (start_read)
	);

	// --------------------------------------------------------------
	// Data path next state
	// --------------------------------------------------------------
	// The holding registers load while their count lasts; leaving the
	// count is what freezes them, so no separate latch pulse is needed.
	// Permanent enable is ignored in byte mode: it would let the second
	// byte overwrite the first.
	always_comb begin
		next_q = q;
		load_upper = byte_mode ? (count == PWBP_SEQ_REQ) :
			(perm_enable || count == PWBP_SEQ_REQ);
		load_lower = byte_mode ?
			(count == PWBP_SEQ_REQ || count == PWBP_SEQ_SECOND) :
			(perm_enable || count == PWBP_SEQ_REQ);
		if (load_upper) begin
			// Word mode takes the lower byte lines, byte mode the upper.
			next_q.hold[HALF-1:0] = byte_mode ?
				dev_rx[DATA_W-1:HALF] : dev_rx[HALF-1:0];
		end
		if (load_lower) begin
			next_q.hold[DATA_W-1:HALF] = dev_rx[DATA_W-1:HALF];
		end
		// Host sees the held word only in answer to a read strobe.
		if (rd_stb) begin
			next_q.rd_data = q.hold;
		end
		if (wr_stb) begin
			next_q.out_word = host_wdata;
		end
		// A new write strobe beats a simultaneous done.
		if (wr_stb) begin
			next_q.wip = 1'b1;
		end else if (op_done) begin
			next_q.wip = 1'b0;
		end
		// Select flop: normal mode needs a write under way, test mode
		// only byte mode, so reads also unpack for loop-back.
		sel_enable = test_write ? byte_mode :
			(next_q.wip && byte_mode);
		next_q.half_sel = sel_enable &&
			(next_count == PWBP_SEQ_IDLE ||
			next_count == PWBP_SEQ_REQ);
		next_q.tx[HALF-1:0] = next_q.out_word[HALF-1:0];
		next_q.tx[DATA_W-1:HALF] = next_q.half_sel ?
			next_q.out_word[HALF-1:0] :
			next_q.out_word[DATA_W-1:HALF];
	end

	// --------------------------------------------------------------
	// State register
	// --------------------------------------------------------------
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			q <= '0;
		end else begin
			q <= next_q;
		end
	end

	assign host_rdata = q.rd_data;
	assign dev_tx = q.tx;

	// --------------------------------------------------------------
	// Checks
	// --------------------------------------------------------------
	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (rst);

	chk_read_present: assert property (
		rd_stb |=> host_rdata == $past(q.hold))
		else $error("read strobe did not present held word");

	chk_word_capture: assert property (
		(!byte_mode && count == PWBP_SEQ_REQ) |=>
			q.hold == $past(dev_rx))
		else $error("word capture did not follow receivers");

	chk_word_freeze: assert property (
		(!byte_mode && !perm_enable && count != PWBP_SEQ_REQ) |=>
			$stable(q.hold))
		else $error("held word changed outside count 1");

	chk_byte_dup: assert property (
		(byte_mode && count == PWBP_SEQ_REQ) |=>
			q.hold[HALF-1:0] == q.hold[DATA_W-1:HALF])
		else $error("first byte not in both halves");

	chk_second_byte: assert property (
		(byte_mode && count == PWBP_SEQ_SECOND) |=>
			(q.hold[HALF-1:0] == $past(q.hold[HALF-1:0]) &&
			q.hold[DATA_W-1:HALF] == $past(dev_rx[DATA_W-1:HALF])))
		else $error("second byte load wrong");

	chk_write_latch: assert property (
		wr_stb |=> (q.out_word == $past(host_wdata) && q.wip))
		else $error("write strobe did not latch word");

	chk_word_drive: assert property (
		!byte_mode ##1 !byte_mode |-> dev_tx == q.out_word)
		else $error("word mode did not send whole word");

	chk_byte_order: assert property (
		(byte_mode && !test_write && q.wip &&
		count inside {PWBP_SEQ_RESP, PWBP_SEQ_SECOND}) |->
			dev_tx[DATA_W-1:HALF] == q.out_word[DATA_W-1:HALF])
		else $error("second half not sent in counts 2 and 3");

	chk_wip_clear: assert property (
		(op_done && !wr_stb) |=> (!q.wip && count == PWBP_SEQ_IDLE))
		else $error("write flag not cleared at done");

	chk_seq_start: assert property (
		(wr_stb && count == PWBP_SEQ_IDLE) |=> count == PWBP_SEQ_REQ)
		else $error("write strobe did not start counter");

	// The select flop lags the control word by one cycle, so both
	// checks below want the mode held for a cycle before they judge.
	chk_test_select: assert property (
		(test_write && byte_mode) ##1 (test_write && byte_mode &&
		count inside {PWBP_SEQ_IDLE, PWBP_SEQ_REQ}) |-> q.half_sel)
		else $error("test write select not high in counts 0 and 1");

	chk_normal_gate: assert property (
		!test_write ##1 (!test_write && !q.wip) |-> !q.half_sel)
		else $error("select set without a write in progress");
endmodule

// *** tb/pwbp_dev_model.sv ***
// Behavioural model of the parallel peripheral on the device lines.
`timescale 1ns/1ns
module pwbp_dev_model (
	// Clock and reset
	input  wire logic        sys_clk,
	input  wire logic        rst,
	// Device lines
	input  wire logic        device_command,
	input  wire logic [15:0] dev_tx,
	output logic             device_flag,
	output logic [15:0]      dev_rx,
	// Bench control and observation
	input  wire logic [15:0] rx_first,
	input  wire logic [15:0] rx_second,
	input  wire logic        two_part,
	input  wire logic [3:0]  lag,
	output logic [15:0]      seen_first,
	output logic [15:0]      seen_second
);
	logic second;

	// One handshake per request; all changes land 1 ns after an edge.
	// Data is spoiled one cycle after the flag rises, so a holding
	// register that keeps loading past its count picks up garbage.
	initial begin
		device_flag = 1'b0;
		dev_rx = 16'h0000;
		seen_first = 16'h0000;
		seen_second = 16'h0000;
		second = 1'b0;
		forever begin
			@(posedge sys_clk);
			#1;
			if (rst) begin
				second = 1'b0;
			end else if (device_command === 1'b1) begin
				dev_rx = second ? rx_second : rx_first;
				repeat (lag) @(posedge sys_clk);
				#1;
				if (second) seen_second = dev_tx;
				else seen_first = dev_tx;
				device_flag = 1'b1;
				@(posedge sys_clk);
				#1 dev_rx = ~dev_rx;
				repeat (lag) @(posedge sys_clk);
				#1 device_flag = 1'b0;
				second = two_part & ~second;
			end
		end
	end
endmodule

// *** tb/pwbp_core_tb_top.sv ***
// Self-checking bench for the word/byte pack-unpack data path.
`timescale 1ns/1ns
`define CHECK(g, e) chk_val(g, e)
module pwbp_core_tb_top;
	import pwbp_pkg::*;

	// ------------------------------------------------------------
	// Signals
	// ------------------------------------------------------------
	localparam logic [15:0] BYTE_C = 16'h0001 << CTRL_BYTE_XFER_BIT;
	localparam logic [15:0] TEST_C = 16'h0001 << CTRL_TEST_WRITE_BIT;
	localparam logic [15:0] GO_C   = 16'h0001 << CTRL_START_READ_BIT;
	localparam logic [15:0] PERM_C = 16'h0001 << CTRL_PERM_ENABLE_BIT;
	logic        sys_clk = 1'b0;
	logic        rst = 1'b1;
	logic [3:0]  strb = 4'h0;
	logic [15:0] host_wdata = 16'h0000;
	logic [15:0] reg_wdata = 16'h0000;
	logic [1:0]  reg_addr = 2'h0;
	logic        reg_wr = 1'b0;
	logic        reg_rd = 1'b0;
	logic [15:0] rx_first = 16'h0000;
	logic [15:0] rx_second = 16'h0000;
	logic        two_part = 1'b0;
	logic [3:0]  lag = 4'h2;
	logic [15:0] host_rdata, reg_rdata, dev_rx, dev_tx;
	logic [15:0] seen_first, seen_second, s;
	logic        device_flag, device_command;
	int          err_total = 0;
	int          samples_checked = 0;
	int          cycles = 0;

	pwbp_core pwbp_core_inst (
		.sys_clk(sys_clk), .rst(rst),
		.direct_read_strobe(strb[0]), .program_read_strobe(strb[1]),
		.direct_write_strobe(strb[2]), .program_write_strobe(strb[3]),
		.host_wdata(host_wdata), .host_rdata(host_rdata),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
		.reg_rd(reg_rd), .reg_rdata(reg_rdata), .dev_rx(dev_rx),
		.device_flag(device_flag), .dev_tx(dev_tx),
		.device_command(device_command)
	);

	pwbp_dev_model pwbp_dev_model_inst (
		.sys_clk(sys_clk), .rst(rst), .device_command(device_command),
		.dev_tx(dev_tx), .device_flag(device_flag), .dev_rx(dev_rx),
		.rx_first(rx_first), .rx_second(rx_second), .two_part(two_part),
		.lag(lag), .seen_first(seen_first), .seen_second(seen_second)
	);

	// ------------------------------------------------------------
	// Shared tasks
	// ------------------------------------------------------------
	task automatic chk_val(input logic [15:0] g, input logic [15:0] e);
		samples_checked++;
		if (g !== e) begin
			err_total++;
			$display("BAD t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask

	// One register access; read data lands in s.
	task automatic reg_acc(input logic wr, input logic [1:0] a,
		input logic [15:0] d);
		@(posedge sys_clk);
		reg_wr <= wr;
		reg_rd <= !wr;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge sys_clk);
		reg_wr <= 1'b0;
		reg_rd <= 1'b0;
		#1 s = reg_rdata;
	endtask

	// One host strobe pulse: 0,1 read, 2,3 write.
	task automatic strobe(input int k, input logic [15:0] d);
		@(posedge sys_clk);
		strb[k] <= 1'b1;
		host_wdata <= d;
		@(posedge sys_clk);
		strb <= 4'h0;
		#1;
	endtask

	// Polls status until counter idle, flag low and no write pending.
	task automatic wait_idle();
		int n;
		n = 0;
		do begin
			reg_acc(1'b0, STAT_OFS, 16'h0000);
			n++;
		end while (n < 200 && (s[STAT_SEQ_LSB+:2] !== 2'b00 ||
			s[STAT_WIP_BIT] !== 1'b0 || s[STAT_FLAG_BIT] !== 1'b0));
		// A poll limit that runs out shows up here only with a busy counter; a stuck write flag or device flag passes.
		`CHECK({14'h0000, s[STAT_SEQ_LSB+:2]}, 16'h0000);
	endtask

	// ------------------------------------------------------------
	// Scenarios
	// ------------------------------------------------------------
	task automatic t_reset();
		`CHECK(host_rdata, 16'h0000);
		`CHECK(dev_tx, 16'h0000);
		reg_acc(1'b0, CTRL_OFS, 16'h0000);
		`CHECK(s, CTRL_RESET);
		reg_acc(1'b1, STAT_OFS, 16'hFFFF);
		reg_acc(1'b0, STAT_OFS, 16'h0000);
		`CHECK(s, 16'h0000);
		reg_acc(1'b1, 2'h2, 16'hFFFF);
		reg_acc(1'b0, 2'h2, 16'h0000);
		`CHECK(s, 16'h0000);
	endtask

	task automatic t_word_read();
		rx_first = 16'hA5C3;
		lag = 4'h4;
		reg_acc(1'b1, CTRL_OFS, GO_C);
		reg_acc(1'b0, STAT_OFS, 16'h0000);
		`CHECK({14'h0000, s[STAT_SEQ_LSB+:2]}, 16'h0001);
		`CHECK({15'h0000, device_command}, 16'h0001);
		wait_idle();
		`CHECK(host_rdata, 16'h0000);
		strobe(0, 16'h0000);
		`CHECK(host_rdata, 16'hA5C3);
	endtask

	task automatic t_byte_read();
		rx_first = 16'h3C00;
		rx_second = 16'h9600;
		two_part = 1'b1;
		lag = 4'h6;
		reg_acc(1'b1, CTRL_OFS, BYTE_C | GO_C);
		reg_acc(1'b0, STAT_OFS, 16'h0000);
		`CHECK({15'h0000, s[STAT_BYTE_BIT]}, 16'h0001);
		wait_idle();
		strobe(1, 16'h0000);
		`CHECK(host_rdata, 16'h963C);
	endtask

	task automatic t_word_write();
		two_part = 1'b0;
		lag = 4'h3;
		reg_acc(1'b1, CTRL_OFS, 16'h0000);
		reg_acc(1'b0, STAT_OFS, 16'h0000);
		`CHECK({15'h0000, s[STAT_BYTE_BIT]}, 16'h0000);
		strobe(3, 16'h1234);
		`CHECK(dev_tx, 16'h1234);
		reg_acc(1'b0, STAT_OFS, 16'h0000);
		`CHECK({15'h0000, s[STAT_WIP_BIT]}, 16'h0001);
		`CHECK({14'h0000, s[STAT_SEQ_LSB+:2]}, 16'h0001);
		wait_idle();
		`CHECK({15'h0000, s[STAT_WIP_BIT]}, 16'h0000);
		`CHECK(seen_first, 16'h1234);
	endtask

	task automatic t_test_write();
		two_part = 1'b1;
		// The select flop follows the control word one cycle later.
		reg_acc(1'b1, CTRL_OFS, BYTE_C);
		@(posedge sys_clk);
		#1;
		`CHECK(dev_tx, 16'h1234);
		reg_acc(1'b1, CTRL_OFS, BYTE_C | TEST_C);
		@(posedge sys_clk);
		#1;
		`CHECK(dev_tx, 16'h3434);
		reg_acc(1'b1, CTRL_OFS, BYTE_C | TEST_C | GO_C);
		wait_idle();
		`CHECK(seen_first, 16'h3434);
		`CHECK(seen_second, 16'h1234);
	endtask

	task automatic t_byte_write();
		lag = 4'h2;
		reg_acc(1'b1, CTRL_OFS, BYTE_C);
		strobe(2, 16'hBEEF);
		wait_idle();
		`CHECK(seen_first, 16'hEFEF);
		`CHECK(seen_second, 16'hBEEF);
	endtask

	// Permanent enable keeps loading after the flag, so the spoiled
	// data that the device leaves behind is what the host reads.
	task automatic t_perm_read();
		rx_first = 16'h5AA5;
		two_part = 1'b0;
		reg_acc(1'b1, CTRL_OFS, PERM_C | GO_C);
		wait_idle();
		strobe(0, 16'h0000);
		`CHECK(host_rdata, 16'hA55A);
	endtask

	// ------------------------------------------------------------
	// Clock, timeout and sequence
	// ------------------------------------------------------------
	task automatic end_of_test();
		$display("checked=%0d errors=%0d", samples_checked, err_total);
		if (err_total == 0 && samples_checked > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask

	// Free-running 50 MHz clock.
	initial begin
		forever #10 sys_clk = ~sys_clk;
	end

	// A hung handshake would stall forever, so cap the run.
	always @(posedge sys_clk) begin
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			err_total++;
			end_of_test();
		end
	end

	// Main sequence; each scenario leaves the counter idle.
	initial begin
		repeat (10) @(posedge sys_clk);
		rst <= 1'b0;
		@(posedge sys_clk);
		#1;
		t_reset();
		t_word_read();
		t_byte_read();
		t_word_write();
		t_test_write();
		t_byte_write();
		t_perm_read();
		end_of_test();
	end
endmodule
